// *** shared/adc_port_pkg.sv ***
// constants, register map and state codes for the converter serial port
package adc_port_pkg;

    // word and register geometry
    localparam int WORD_W    = 16;
    localparam int DATA_W    = 12;
    localparam int ADDR_W    = 4;
    localparam int BIT_CNT_W = 5;
    localparam int NUM_REGS  = 14;
    localparam int FIFO_DEPTH = 32;

    // register indices carried in the top nibble of a written word
    localparam logic [ADDR_W-1:0] NULL_IDX   = 4'h0;
    localparam logic [ADDR_W-1:0] CTRL_IDX   = 4'h1;
    localparam logic [ADDR_W-1:0] STATUS_IDX = 4'h2;
    localparam logic [ADDR_W-1:0] TEST_IDX   = 4'h4;

    // reset contents
    localparam logic [DATA_W-1:0] REG_RESET  = 12'h000;
    localparam logic [DATA_W-1:0] TEST_RESET = 12'h002;

    // control register fields
    localparam int CTRL_TWO_WIRE  = 0;
    localparam int CTRL_START     = 1;
    localparam int CTRL_CH_LSB    = 2;
    localparam int CTRL_CH_W      = 3;
    localparam int CTRL_RD_STATUS = 5;
    localparam int CTRL_CAL_RD    = 6;
    localparam int CTRL_CAL_WR    = 7;

    // status register fields
    localparam int ST_BUSY      = 0;
    localparam int ST_CAL       = 1;
    localparam int ST_TWO_WIRE  = 2;
    localparam int ST_FIFO_FULL = 3;

    // timing, in master clock rising edges
    localparam int CAL_TIME_MS     = 32;
    localparam int MCLK_KHZ        = 4000;
    localparam int CAL_MCLK_EDGES  = CAL_TIME_MS * MCLK_KHZ;
    localparam int ACQ_MCLK        = 2;
    localparam int CONV_MCLK       = 18;
    localparam int CAL_BURST_WORDS = 4;
    localparam int CNT_W           = 20;

    // pin synchroniser lanes and their idle levels
    localparam int SYNC_W = 5;
    localparam int P_SCLK = 0;
    localparam int P_SYNC = 1;
    localparam int P_DIN  = 2;
    localparam int P_CONV = 3;
    localparam int P_MCLK = 4;
    localparam logic [SYNC_W-1:0] PIN_IDLE = 5'h0b;

    // conversion sequencer
    typedef enum logic [3:0] {
        CV_CAL  = 4'b0001,
        CV_IDLE = 4'b0010,
        CV_ACQ  = 4'b0100,
        CV_CONV = 4'b1000
    } conv_state_e;

endpackage

// *** core/word_fifo.sv ***
// word fifo with registered head, valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic [WIDTH-1:0] head_q, head_d;
    logic             ov_q, ov_d;
    logic             push, load;

    // pointer and head update; head register refills when consumed
    always_comb
    begin
        in_ready = (cnt_q != (AW+1)'(DEPTH));
        push     = in_valid && in_ready;
        load     = (cnt_q != '0) && (!ov_q || out_ready);
        wr_d     = push ? wr_q + 1'b1 : wr_q;
        rd_d     = load ? rd_q + 1'b1 : rd_q;
        cnt_d    = cnt_q + (AW+1)'(push) - (AW+1)'(load);
        head_d   = load ? mem_q[rd_q] : head_q;
        ov_d     = load ? 1'b1 : (out_ready ? 1'b0 : ov_q);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q   <= '0;
            rd_q   <= '0;
            cnt_q  <= '0;
            head_q <= '0;
            ov_q   <= 1'b0;
        end
        else
        begin
            wr_q   <= wr_d;
            rd_q   <= rd_d;
            cnt_q  <= cnt_d;
            head_q <= head_d;
            ov_q   <= ov_d;
        end
    end

    // storage needs no reset
    always_ff @(posedge clk)
    begin
        if (push)
            mem_q[wr_q] <= in_data;
    end

    assign out_valid = ov_q;
    assign out_data  = head_q;
endmodule
`default_nettype wire

// *** core/adc_serial_port.sv ***
// serial host port of the sampling converter: 2-wire and 3-wire modes
//
// Functional notes
// (R01) frame fall with serial clock low drives MSB; else first clock fall does.
// (R02) data changes on clock falls, sampled on clock rises.
// (R03) master idles a gated serial clock high.
// (R04) frame high clears shift state; next frame starts a fresh 16-bit word.
// (R05) master may rewrite test register with 0x4002 after interface reset.
// (R06) powers up 3-wire; 2-wire only via control write with mode bit.
// (R07) master keeps the mode bit set in every 2-wire write.
// (R08) conversion starts on pin pulse or control write of start bit.
// (R09) 2-wire pulsed frame: sample on rises, pin becomes output after 16th rise.
// (R10) 2-wire: frame high floats pin; frame low drives; back to input after 16.
// (R11) 2-wire free-running clock needs exactly 16 pulses per frame.
// (R12) 2-wire tied-low frame: never floats, direction flips each 16th rise.
// (R13) calibration bursts keep pin output for reads, input for writes.
// (R14) 3-wire: frame low enables output, first fall drives leading zero.
// (R15) 3-wire: master gives exactly 16 pulses per transfer.
// (R16) fourteen registers reachable through serial writes; code writes 13, index 2 (status) is read-only.
// (R17) power-up calibration runs on master clock edges only, about 32 ms.
// (R18) 2-wire mode never reads and writes in the same phase.
// (R19) status busy bit reads 0 at end of conversion.
// (R20) channel change and command start need two separate writes.
// (R21) 3-wire shifts read data out and write data in together.
// (R22) busy falling clears start bit; later write may set it again.
// (R23) words move MSB first, edges counted from each frame start.
`timescale 1ns/1ps
`default_nettype none
module adc_serial_port #(
    parameter int CAL_EDGES  = adc_port_pkg::CAL_MCLK_EDGES,
    parameter int CONV_EDGES = adc_port_pkg::CONV_MCLK,
    parameter int CAL_WORDS  = adc_port_pkg::CAL_BURST_WORDS,
    parameter int FIFO_DEPTH = adc_port_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RESET_N,
    // serial link pins
    input  wire logic        SCLK,
    input  wire logic        SYNC_N,
    input  wire logic        DIN_I,
    output logic             DIN_O,
    output logic             DIN_OE,
    output logic             DOUT,
    output logic             DOUT_OE,
    // converter pins
    input  wire logic        CONVERSION_START_N,
    input  wire logic        MASTER_CLOCK_INPUT,
    input  wire logic [11:0] ADC_RESULT,
    // status
    output logic             BUSY,
    output logic             CAL_BUSY,
    output logic             TWO_WIRE,
    output logic [2:0]       CHANNEL,
    output logic             RX_READY
);
    localparam int W  = adc_port_pkg::WORD_W;
    localparam int DW = adc_port_pkg::DATA_W;
    localparam int AW = adc_port_pkg::ADDR_W;
    localparam int CW = adc_port_pkg::CNT_W;
    localparam int BW = adc_port_pkg::BIT_CNT_W;
    localparam logic [BW-1:0] LAST_BIT = BW'(W - 1);

    function automatic logic rise_of(input logic cur, input logic prev);
        return cur && !prev;
    endfunction

    // two-stage synchroniser for every single-bit link and converter input, third stage for edges
    logic [adc_port_pkg::SYNC_W-1:0] meta_q, pin_q, prev_q;
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            meta_q <= adc_port_pkg::PIN_IDLE;
            pin_q  <= adc_port_pkg::PIN_IDLE;
            prev_q <= adc_port_pkg::PIN_IDLE;
        end
        else
        begin
            meta_q <= {MASTER_CLOCK_INPUT, CONVERSION_START_N, DIN_I, SYNC_N, SCLK};
            pin_q  <= meta_q;
            prev_q <= pin_q;
        end
    end

    logic s_sclk, frame, frame_start, sclk_rise, sclk_fall, pin_start, mclk_rise;
    assign s_sclk      = pin_q[adc_port_pkg::P_SCLK];
    assign frame       = !pin_q[adc_port_pkg::P_SYNC];
    assign frame_start = frame && prev_q[adc_port_pkg::P_SYNC];
    assign sclk_rise   = rise_of(s_sclk, prev_q[adc_port_pkg::P_SCLK]);
    assign sclk_fall   = rise_of(prev_q[adc_port_pkg::P_SCLK], s_sclk);
    assign pin_start   = rise_of(pin_q[adc_port_pkg::P_CONV], prev_q[adc_port_pkg::P_CONV]);
    assign mclk_rise   = rise_of(pin_q[adc_port_pkg::P_MCLK], prev_q[adc_port_pkg::P_MCLK]);

    // register file, conversion sequencer and receive fifo wiring
    logic [DW-1:0]                    regs_q [1:adc_port_pkg::NUM_REGS];
    logic [DW-1:0]                    regs_d [1:adc_port_pkg::NUM_REGS];
    adc_port_pkg::conv_state_e        cv_q, cv_d;
    logic [CW-1:0]                    ccnt_q, ccnt_d;
    logic [DW-1:0]                    result_q, result_d;
    logic                             cal_rd_go_q, cal_rd_go_d, cal_wr_go_q, cal_wr_go_d;
    logic                             fifo_in_ready, fifo_ov, fifo_ordy, pop;
    logic [W-1:0]                     fifo_word;
    logic [AW-1:0]                    waddr;
    logic [DW-1:0]                    wdata, status_w;
    logic                             ctrl_wr, start_wr, two_wire, busy;

    // serial engine state
    logic [W-1:0]  rx_q, rx_d, tx_q, tx_d, word_q, word_d, rd_word;
    logic [BW-1:0] cnt_q, cnt_d;
    logic          shown_q, shown_d, dir_q, dir_d, push_q, push_d;
    logic [CW-1:0] calr_q, calr_d, calw_q, calw_d;

    assign two_wire = regs_q[adc_port_pkg::CTRL_IDX][adc_port_pkg::CTRL_TWO_WIRE];
    assign busy     = (cv_q != adc_port_pkg::CV_IDLE);

    // status word; busy reads 0 once the result is ready
    always_comb
    begin
        status_w = '0;
        status_w[adc_port_pkg::ST_BUSY]      = busy; // R19
        status_w[adc_port_pkg::ST_CAL]       = (cv_q == adc_port_pkg::CV_CAL);
        status_w[adc_port_pkg::ST_TWO_WIRE]  = two_wire;
        status_w[adc_port_pkg::ST_FIFO_FULL] = !fifo_in_ready;
        rd_word = {{(W-DW){1'b0}},
                   regs_q[adc_port_pkg::CTRL_IDX][adc_port_pkg::CTRL_RD_STATUS] ?
                   status_w : result_q};
    end

    // serial shifting: outgoing bits on falls, incoming on rises
    always_comb
    begin
        rx_d    = rx_q;
        tx_d    = tx_q;
        cnt_d   = cnt_q;
        shown_d = shown_q;
        dir_d   = two_wire ? dir_q : 1'b0;
        push_d  = 1'b0;
        word_d  = word_q;
        calr_d  = cal_rd_go_q ? CW'(CAL_WORDS - 1) : calr_q;
        calw_d  = cal_wr_go_q ? CW'(CAL_WORDS - 1) : calw_q;
        if (!frame)
        begin
            rx_d    = '0; // R04
            cnt_d   = '0; // R04
            shown_d = 1'b0;
            tx_d    = rd_word;
        end
        else
        begin
            if (frame_start)
                shown_d = !s_sclk; // R01
            else if (sclk_fall)
            begin
                if (shown_q)
                    tx_d = {tx_q[W-2:0], 1'b0}; // R02 R23
                else
                    shown_d = 1'b1; // R01 R14
            end
            if (sclk_rise)
            begin
                rx_d  = {rx_q[W-2:0], pin_q[adc_port_pkg::P_DIN]}; // R02 R23
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == LAST_BIT)
                begin
                    cnt_d   = '0; // R23
                    shown_d = 1'b0;
                    tx_d    = rd_word;
                    // single pin in 2-wire mode: only input phases deliver words
                    if (!two_wire || !dir_q)
                    begin
                        push_d = 1'b1; // R18 R21
                        word_d = {rx_q[W-2:0], pin_q[adc_port_pkg::P_DIN]};
                    end
                    if (two_wire && dir_q)
                    begin
                        if (calr_q != '0)
                            calr_d = calr_q - 1'b1; // R13
                        else
                            dir_d = 1'b0; // R10 R12
                    end
                    else if (two_wire)
                    begin
                        if (calw_q != '0)
                            calw_d = calw_q - 1'b1; // R13
                        else
                            dir_d = 1'b1; // R09 R12
                    end
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rx_q    <= '0;
            tx_q    <= '0;
            cnt_q   <= '0;
            shown_q <= 1'b0;
            dir_q   <= 1'b0;
            push_q  <= 1'b0;
            word_q  <= '0;
            calr_q  <= '0;
            calw_q  <= '0;
        end
        else
        begin
            rx_q    <= rx_d;
            tx_q    <= tx_d;
            cnt_q   <= cnt_d;
            shown_q <= shown_d;
            dir_q   <= dir_d;
            push_q  <= push_d;
            word_q  <= word_d;
            calr_q  <= calr_d;
            calw_q  <= calw_d;
        end
    end

    // received words queue here; drain stalls during calibration
    word_fifo #(
        .WIDTH (W),
        .DEPTH (FIFO_DEPTH)
    ) rx_fifo (
        .clk       (CLK_SYS),
        .rst_n     (RESET_N),
        .in_valid  (push_q),
        .in_ready  (fifo_in_ready),
        .in_data   (word_q),
        .out_valid (fifo_ov),
        .out_ready (fifo_ordy),
        .out_data  (fifo_word)
    );
    assign fifo_ordy = (cv_q != adc_port_pkg::CV_CAL);

    // register writes on fifo pops, conversion sequencing on master clock edges
    always_comb
    begin
        regs_d      = regs_q;
        cv_d        = cv_q;
        ccnt_d      = ccnt_q;
        result_d    = result_q;
        pop         = fifo_ov && fifo_ordy;
        waddr       = fifo_word[W-1:DW];
        wdata       = fifo_word[DW-1:0];
        ctrl_wr     = pop && (waddr == adc_port_pkg::CTRL_IDX);
        start_wr    = ctrl_wr && wdata[adc_port_pkg::CTRL_START];
        cal_rd_go_d = ctrl_wr && wdata[adc_port_pkg::CTRL_CAL_RD];
        cal_wr_go_d = ctrl_wr && wdata[adc_port_pkg::CTRL_CAL_WR];
        // index zero is a no-op word; status is read-only
        if (pop && waddr != adc_port_pkg::NULL_IDX && waddr != adc_port_pkg::STATUS_IDX
            && waddr <= AW'(adc_port_pkg::NUM_REGS))
            regs_d[waddr] = wdata; // R16 R06 R07
        unique case (cv_q)
            adc_port_pkg::CV_CAL:
                if (mclk_rise) // R17
                begin
                    ccnt_d = ccnt_q + 1'b1;
                    if (ccnt_q == CW'(CAL_EDGES - 1))
                    begin
                        ccnt_d = '0;
                        cv_d   = adc_port_pkg::CV_IDLE;
                    end
                end
            adc_port_pkg::CV_IDLE:
                if (pin_start || start_wr)
                begin
                    ccnt_d = '0;
                    cv_d   = adc_port_pkg::CV_ACQ; // R08
                end
            adc_port_pkg::CV_ACQ:
                if (mclk_rise) // R20
                begin
                    ccnt_d = ccnt_q + 1'b1;
                    if (ccnt_q == CW'(adc_port_pkg::ACQ_MCLK - 1))
                    begin
                        ccnt_d = '0;
                        cv_d   = adc_port_pkg::CV_CONV;
                    end
                end
            adc_port_pkg::CV_CONV:
                if (mclk_rise)
                begin
                    ccnt_d = ccnt_q + 1'b1;
                    if (ccnt_q == CW'(CONV_EDGES - 1))
                    begin
                        ccnt_d   = '0;
                        cv_d     = adc_port_pkg::CV_IDLE;
                        result_d = ADC_RESULT;
                        // a write landing on the busy fall keeps its start bit
                        if (!start_wr)
                            regs_d[adc_port_pkg::CTRL_IDX][adc_port_pkg::CTRL_START] = 1'b0; // R22
                    end
                end
            default:
                cv_d = adc_port_pkg::CV_CAL;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            for (int i = 1; i <= adc_port_pkg::NUM_REGS; i++)
                regs_q[i] <= adc_port_pkg::REG_RESET; // R06
            regs_q[adc_port_pkg::TEST_IDX] <= adc_port_pkg::TEST_RESET; // R05
            cv_q        <= adc_port_pkg::CV_CAL; // R17
            ccnt_q      <= '0;
            result_q    <= '0;
            cal_rd_go_q <= 1'b0;
            cal_wr_go_q <= 1'b0;
        end
        else
        begin
            regs_q      <= regs_d;
            cv_q        <= cv_d;
            ccnt_q      <= ccnt_d;
            result_q    <= result_d;
            cal_rd_go_q <= cal_rd_go_d;
            cal_wr_go_q <= cal_wr_go_d;
        end
    end

    // pins and status registered; one sys cycle is far below a serial half period
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            DIN_O    <= 1'b0;
            DIN_OE   <= 1'b0;
            DOUT     <= 1'b0;
            DOUT_OE  <= 1'b0;
            BUSY     <= 1'b1;
            CAL_BUSY <= 1'b1;
            TWO_WIRE <= 1'b0;
            CHANNEL  <= '0;
            RX_READY <= 1'b1;
        end
        else
        begin
            DIN_O    <= shown_q && tx_q[W-1];
            DIN_OE   <= two_wire && frame && dir_q; // R10 R12
            DOUT     <= shown_q && tx_q[W-1];
            DOUT_OE  <= !two_wire && frame; // R14
            BUSY     <= busy;
            CAL_BUSY <= (cv_q == adc_port_pkg::CV_CAL);
            TWO_WIRE <= two_wire;
            CHANNEL  <= regs_q[adc_port_pkg::CTRL_IDX][adc_port_pkg::CTRL_CH_LSB +: 3];
            RX_READY <= fifo_in_ready;
        end
    end

    msb_first_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R01
        frame_start && !s_sclk |=> shown_q)
        else $error("msb not shown at frame fall with clock low");
    fall_shift_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R02
        frame && sclk_fall && shown_q && !frame_start
        |=> tx_q == {$past(tx_q[W-2:0]), 1'b0})
        else $error("outgoing word did not shift on clock fall");
    frame_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R04
        !frame |=> (cnt_q == '0) && (rx_q == '0))
        else $error("shift state not cleared while frame high");
    mode_write_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R06
        $changed(two_wire) |-> $past(ctrl_wr))
        else $error("interface mode changed without control write");
    conv_start_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R08
        cv_q == adc_port_pkg::CV_IDLE && (pin_start || start_wr)
        |=> cv_q == adc_port_pkg::CV_ACQ ##1 BUSY)
        else $error("conversion did not start");
    turn_output_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R09
        frame && two_wire && !dir_q && sclk_rise && cnt_q == LAST_BIT && calw_q == '0
        && !cal_wr_go_q |=> dir_q ##1 (DIN_OE || !frame))
        else $error("shared pin did not turn after sixteenth rise");
    pin_float_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R10
        !frame |=> !DIN_OE)
        else $error("shared pin driven outside frame");
    dout_enable_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R14
        frame && !two_wire |=> DOUT_OE && !DIN_OE)
        else $error("3-wire output not enabled in frame");
    cal_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R17
        cv_q == adc_port_pkg::CV_CAL && !mclk_rise |=> $stable(ccnt_q) && CAL_BUSY)
        else $error("calibration advanced without master clock");
    no_both_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R18
        push_q && two_wire |-> !$past(dir_q))
        else $error("word accepted during 2-wire output phase");
    start_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R22
        $fell(busy) && !$past(start_wr)
        |-> !regs_q[adc_port_pkg::CTRL_IDX][adc_port_pkg::CTRL_START])
        else $error("start bit not cleared at busy fall");
    word_len_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R23
        cnt_q <= LAST_BIT)
        else $error("bit counter passed word length");
endmodule
`default_nettype wire

// *** verif/serial_master_model.sv ***
// serial master model driving the converter port link pins
`timescale 1ns/1ps
`default_nettype none
module serial_master_model (
    // link pins
    output logic      sclk,
    output logic      sync_n,
    output logic      mosi,
    output logic      mosi_oe,
    // data returned by the port
    input  wire logic miso
);
    localparam time HALF = 80ns;
    // gated clock idles high between frames
    initial
    begin
        sclk = 1'b1;
        sync_n = 1'b1;
        mosi = 1'b0;
        mosi_oe = 1'b0;
    end
    // frame select, then half a period of settling
    task automatic select(input logic on);
        sync_n = ~on;
        #(HALF);
    endtask
    // n bits of a word, msb first; drive on fall, capture on rise
    task automatic word(input logic [15:0] tx, input logic drv, input int n,
                        output logic [15:0] rx);
        rx = 16'h0000;
        for (int i = 15; i >= 16 - n; i--)
        begin
            sclk = 1'b0;
            mosi_oe = drv;
            mosi = drv ? tx[i] : ~mosi;
            #(HALF);
            sclk = 1'b1;
            rx[i] = miso;
            // free the shared pin after the last rise, before the port turns it
            #(HALF / 4);
            if (i == 16 - n)
                mosi_oe = 1'b0;
            #(HALF - HALF / 4);
        end
        mosi_oe = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** verif/adc_serial_port_tb_top.sv ***
// self-checking bench for the converter serial port
`timescale 1ns/1ps
`default_nettype none
module adc_serial_port_tb_top;
    logic        clk_sys, reset_n, conv_n, mclk, din_o, din_oe, dout, dout_oe;
    logic        busy, cal_busy, two_wire, rx_ready, clash;
    logic [11:0] result;
    logic [2:0]  channel;
    logic [15:0] rx;
    wire logic   sclk, sync_n, mosi, mosi_oe, din_w, miso;
    int          n_fail, check_count;

    // shared pin level; nobody driving shows the inverse of the last bit
    assign din_w = mosi_oe ? mosi : (din_oe ? din_o : ~mosi);
    assign miso  = two_wire ? din_w : dout;

    adc_serial_port #(
        .CAL_EDGES          (20),
        .CONV_EDGES         (4)
    ) adc_serial_port_inst (
        .CLK_SYS            (clk_sys),
        .RESET_N            (reset_n),
        .SCLK               (sclk),
        .SYNC_N             (sync_n),
        .DIN_I              (din_w),
        .DIN_O              (din_o),
        .DIN_OE             (din_oe),
        .DOUT               (dout),
        .DOUT_OE            (dout_oe),
        .CONVERSION_START_N (conv_n),
        .MASTER_CLOCK_INPUT (mclk),
        .ADC_RESULT         (result),
        .BUSY               (busy),
        .CAL_BUSY           (cal_busy),
        .TWO_WIRE           (two_wire),
        .CHANNEL            (channel),
        .RX_READY           (rx_ready)
    );
    serial_master_model serial_master_model_inst (
        .sclk    (sclk),
        .sync_n  (sync_n),
        .mosi    (mosi),
        .mosi_oe (mosi_oe),
        .miso    (miso)
    );

    // clocks: system at 100 MHz, master clock at 4 MHz
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial
    begin
        mclk = 1'b0;
        // offset keeps master clock edges off the system clock edges
        #1;
        forever #125 mclk = ~mclk;
    end
    // both ends driving the shared pin at once is a fault
    always @(posedge clk_sys)
        if (!reset_n)
            clash <= 1'b0;
        else if (mosi_oe && din_oe)
            clash <= 1'b1;

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // bounded wait for the converter to go idle
    task automatic wait_idle();
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) cycles(1);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic t_power_up();
        check("busy", 1, busy);
        check("mode", 0, two_wire);
        check("channel", 0, channel);
        check("dout_oe", 0, dout_oe);
        check("rx_ready", 1, rx_ready);
        wait_idle();
        check("cal_busy", 0, cal_busy);
    endtask
    task automatic t_pin_start_read();
        result = 12'ha5c;
        conv_n = 1'b0;
        cycles(3);
        conv_n = 1'b1;
        cycles(8);
        check("busy", 1, busy);
        wait_idle();
        check("busy", 0, busy);
        serial_master_model_inst.select(1'b1);
        check("dout_oe", 1, dout_oe);
        serial_master_model_inst.word(16'h1014, 1'b1, 16, rx);
        check("read", 16'h0a5c, rx);
        serial_master_model_inst.select(1'b0);
        check("dout_oe", 0, dout_oe);
        check("channel", 3'h5, channel);
    endtask
    task automatic t_frame_abort();
        serial_master_model_inst.select(1'b1);
        serial_master_model_inst.word(16'hffff, 1'b1, 5, rx);
        serial_master_model_inst.select(1'b0);
        serial_master_model_inst.select(1'b1);
        serial_master_model_inst.word(16'h4002, 1'b1, 16, rx);
        serial_master_model_inst.select(1'b0);
        serial_master_model_inst.select(1'b1);
        serial_master_model_inst.word(16'h100c, 1'b1, 16, rx);
        serial_master_model_inst.select(1'b0);
        check("channel", 3'h3, channel);
    endtask
    task automatic t_soft_start();
        result = 12'h3c1;
        serial_master_model_inst.select(1'b1);
        serial_master_model_inst.word(16'h100e, 1'b1, 16, rx);
        serial_master_model_inst.select(1'b0);
        cycles(10);
        check("busy", 1, busy);
        wait_idle();
        cycles(100);
        check("busy", 0, busy);
        serial_master_model_inst.select(1'b1);
        serial_master_model_inst.word(16'h0000, 1'b1, 16, rx);
        serial_master_model_inst.select(1'b0);
        check("read", 16'h03c1, rx);
    endtask
    task automatic t_two_wire();
        serial_master_model_inst.select(1'b1);
        serial_master_model_inst.word(16'h1001, 1'b1, 16, rx);
        serial_master_model_inst.select(1'b0);
        check("mode", 1, two_wire);
        check("din_oe", 0, din_oe);
        serial_master_model_inst.select(1'b1);
        serial_master_model_inst.word(16'h1001, 1'b1, 16, rx);
        check("din_oe", 1, din_oe);
        serial_master_model_inst.word(16'h0000, 1'b0, 16, rx);
        check("read", 16'h03c1, rx);
        check("din_oe", 0, din_oe);
        serial_master_model_inst.select(1'b0);
        check("clash", 0, clash);
    endtask

    // reset, then the scenarios in order
    initial
    begin
        n_fail = 0;
        check_count = 0;
        reset_n = 1'b0;
        conv_n = 1'b1;
        result = 12'h000;
        cycles(4);
        reset_n = 1'b1;
        cycles(2);
        t_power_up();
        t_pin_start_read();
        t_frame_abort();
        t_soft_start();
        t_two_wire();
        conclude();
    end
    // watchdog well past the expected run length
    initial
    begin
        #200us;
        n_fail++;
        $display("FAIL watchdog expected done seen hang");
        conclude();
    end
endmodule
`default_nettype wire
